// ===== include/led_cfg_pkg.sv
// Operation
// - Config bit 7 set clears the supply-low flag at each movie or picture end.
// - Config bit 6 clear lets supply-low update status and raise the pin normally.
// - Config bit 6 set drives the pin from the supply-low flag; status still updates.
// - Config bit 5 set disables LEDs found open; clear keeps them enabled.
// - Config bit 3 set makes the device answer the shared address 0111111.
// - Layout field 000 is invalid and the reset value; 001..110 pick layouts 1..6.
// - Layout and dot correction lock on first data-section write until reset.
// - Mask bit 7 raises the pin when the target frame has been displayed.
// - Mask bit 6 raises the pin on a bus watchdog event, else never.
// - Mask bit 5 raises the pin while power-on reset is active; mask resets 0x20.
// - Mask bit 4 raises the pin when the overtemperature limit is reached.
// - Mask bit 3 raises the pin while the supply-low flag is set.
// - Mask bit 2 raises the pin when the LED open test reports an error.
// - Mask bit 1 raises the pin when the LED short test reports an error.
// - Mask bit 0 raises the pin when a movie finishes.
// - Frame event fires on the last display of the target frame; target resets 111111.
package led_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET    = 8'h06;
  localparam logic [7:0] MASK_OFFSET   = 8'h07;
  localparam logic [7:0] TFRAME_OFFSET = 8'h08;

  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h20;
  localparam logic [5:0] TFRAME_RESET  = 6'h3F;

  // ----------------------------------------------------------------
  // Field positions (mask bits double as status bit positions)
  // ----------------------------------------------------------------
  localparam int BIT_FRAME   = 7;
  localparam int BIT_WDOG    = 6;
  localparam int BIT_POR     = 5;
  localparam int BIT_THERMAL = 4;
  localparam int BIT_SUPPLY  = 3;
  localparam int BIT_OPEN    = 2;
  localparam int BIT_SHORT   = 1;
  localparam int BIT_MOVIE   = 0;

  localparam logic [2:0] LAYOUT_INVALID = 3'h0;
  localparam logic [2:0] LAYOUT_FIRST   = 3'h1;
  localparam logic [2:0] LAYOUT_LAST    = 3'h6;
  localparam logic [6:0] SHARED_ADDR    = 7'h3F;

  // Configuration register image, bit 7 down to bit 0
  typedef struct packed {
    logic       autoclr;
    logic       sup_to_pin;
    logic       open_dis;
    logic       dot_corr;
    logic       shared_addr;
    logic [2:0] layout;
  } cfg_t;

  // Events and levels from the scan engine, player, tests and monitors
  typedef struct packed {
    logic       frame_shown;
    logic [5:0] frame_num;
    logic       last_loop;
    logic       movie_end;
    logic       pic_end;
    logic       wdog_fire;
    logic       por_active;
    logic       overtemp;
    logic       supply_low;
    logic       open_err;
    logic       short_err;
  } evt_t;

endpackage

// ===== core/status_bits.sv
`timescale 1ns/10ps
module status_bits
  import led_cfg_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,    // System clock
  input  wire logic         nrst,   // Async reset, active low
  input  wire logic [W-1:0] set,    // Event per bit
  input  wire logic [W-1:0] clr,    // Clear per bit
  output logic      [W-1:0] q       // Sticky bits
);

  // ----------------------------------------------------------------
  // Sticky bits, one flop each
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle is kept
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        q[i] <= 1'b0;
      end else if (set[i]) begin
        q[i] <= 1'b1;
      end else if (clr[i]) begin
        q[i] <= 1'b0;
      end
    end
  end

endmodule

// ===== core/frame_tracker.sv
`timescale 1ns/10ps
module frame_tracker
  import led_cfg_pkg::*;
(
  input  wire logic       clk,          // System clock
  input  wire logic       nrst,         // Async reset, active low
  input  wire logic       frame_shown,  // Pulse, a frame finished display
  input  wire logic [5:0] frame_num,    // Number of that frame
  input  wire logic       last_loop,    // Player is in its final loop
  input  wire logic [5:0] target,       // Interrupt target frame
  output logic            hit           // Pulse, target shown last time
);

  // ----------------------------------------------------------------
  // Last-display detect
  // ----------------------------------------------------------------
  // Earlier loops show the same frame too; only the final one counts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hit <= 1'b0;
    end else begin
      hit <= frame_shown && last_loop && (frame_num == target);
    end
  end

endmodule

// ===== core/led_cfg_regs.sv
`timescale 1ns/10ps
module led_cfg_regs
  import led_cfg_pkg::*;
(
  input  wire logic       CLK,             // System clock, 100 MHz
  input  wire logic       NRST,            // Async reset, active low
  // Register port from the serial bus front end
  input  wire logic [7:0] REG_ADDR,        // Register offset
  input  wire logic [7:0] REG_WDATA,       // Write data
  input  wire logic       REG_WE,          // Write strobe
  input  wire logic       REG_RE,          // Read strobe
  output logic      [7:0] REG_RDATA,       // Read data, one cycle after strobe
  input  wire logic       DATA_WR,         // Write into on/off, PWM or DC data
  // Bus address matching
  input  wire logic [6:0] BUS_ADDR,        // Address seen on the bus
  input  wire logic       ADDR_VALID,      // Pulse, address phase done
  input  wire logic [6:0] DEV_ADDR,        // Own device address
  output logic            ADDR_MATCH,      // Pulse, address is ours
  // Events
  input  evt_t            EVENTS,          // Event and level sources
  input  wire logic [7:0] STATUS_CLR,      // Clear of status bits
  output logic      [7:0] STATUS,          // Sticky interrupt status
  output logic            SUPPLY_LOW_FLAG, // Supply-low flag
  output logic            IRQ_REQ,         // Interrupt pin request, high active
  // LED open handling
  input  wire logic       OPEN_FOUND,      // Pulse, open LED found
  input  wire logic [7:0] OPEN_IDX,        // Index of that LED
  output logic            LED_DISABLE,     // Pulse, disable that LED
  output logic      [7:0] LED_DISABLE_IDX, // LED to disable
  // Configuration to the rest of the device
  output logic      [2:0] MEM_LAYOUT,      // Memory layout select
  output logic            LAYOUT_VALID,    // Layout in 1..6
  output logic            DOT_CORR_EN,     // Analog dot correction on
  output logic            CFG_LOCKED       // Layout and dot correction locked
);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cfg_t       cfg_q;
  logic [7:0] mask_q;
  logic [5:0] tframe_q;
  logic       lock_q;
  logic       flag_q;
  logic [7:0] src;
  logic [7:0] status_q;
  logic       frame_hit;
  logic       end_of_show;
  logic       wr_cfg;
  logic       wr_mask;
  logic       wr_tframe;
  cfg_t       wcfg;

  assign wr_cfg      = REG_WE && (REG_ADDR == CFG_OFFSET);
  assign wr_mask     = REG_WE && (REG_ADDR == MASK_OFFSET);
  assign wr_tframe   = REG_WE && (REG_ADDR == TFRAME_OFFSET);
  assign wcfg        = cfg_t'(REG_WDATA);
  assign end_of_show = EVENTS.movie_end || EVENTS.pic_end;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Locked fields keep their value; the rest of the byte still writes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q <= cfg_t'(CFG_RESET);
    end else if (wr_cfg) begin
      cfg_q.autoclr     <= wcfg.autoclr;
      cfg_q.sup_to_pin  <= wcfg.sup_to_pin;
      cfg_q.open_dis    <= wcfg.open_dis;
      cfg_q.shared_addr <= wcfg.shared_addr;
      if (!lock_q) begin
        cfg_q.dot_corr <= wcfg.dot_corr;
        cfg_q.layout   <= wcfg.layout;
      end
    end
  end

  // Lock is only released by reset, never by software
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lock_q <= 1'b0;
    end else if (DATA_WR) begin
      lock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Mask and target frame registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= REG_WDATA;
    end
  end

  // Upper two bits are not stored and read back as zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tframe_q <= TFRAME_RESET;
    end else if (wr_tframe) begin
      tframe_q <= REG_WDATA[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      unique case (REG_ADDR)
        CFG_OFFSET:    REG_RDATA <= cfg_q;
        MASK_OFFSET:   REG_RDATA <= mask_q;
        TFRAME_OFFSET: REG_RDATA <= {2'h0, tframe_q};
        default:       REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus address match
  // ----------------------------------------------------------------
  // Shared address lets one write reach every driver at once
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ADDR_MATCH <= 1'b0;
    end else begin
      ADDR_MATCH <= ADDR_VALID && ((BUS_ADDR == DEV_ADDR) ||
                    (cfg_q.shared_addr && (BUS_ADDR == SHARED_ADDR)));
    end
  end

  // ----------------------------------------------------------------
  // Supply-low flag
  // ----------------------------------------------------------------
  // A new detection wins over the end-of-show clear
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flag_q <= 1'b0;
    end else if (EVENTS.supply_low) begin
      flag_q <= 1'b1;
    end else if (end_of_show && cfg_q.autoclr) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event sources and status
  // ----------------------------------------------------------------
  frame_tracker u_frame (
    .clk         (CLK),
    .nrst        (NRST),
    .frame_shown (EVENTS.frame_shown),
    .frame_num   (EVENTS.frame_num),
    .last_loop   (EVENTS.last_loop),
    .target      (tframe_q),
    .hit         (frame_hit)
  );

  // Status records every source whatever the mask says
  always_comb begin
    src              = 8'h00;
    src[BIT_FRAME]   = frame_hit;
    src[BIT_WDOG]    = EVENTS.wdog_fire;
    src[BIT_POR]     = EVENTS.por_active;
    src[BIT_THERMAL] = EVENTS.overtemp;
    src[BIT_SUPPLY]  = flag_q;
    src[BIT_OPEN]    = EVENTS.open_err;
    src[BIT_SHORT]   = EVENTS.short_err;
    src[BIT_MOVIE]   = EVENTS.movie_end;
  end

  status_bits #(
    .W (8)
  ) u_status (
    .clk  (CLK),
    .nrst (NRST),
    .set  (src),
    .clr  (STATUS_CLR),
    .q    (status_q)
  );

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // In supply-pin mode the pin serves an external converter, so the
  // masked OR is ignored; status keeps recording all the same
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ_REQ <= 1'b0;
    end else if (cfg_q.sup_to_pin) begin
      IRQ_REQ <= flag_q;
    end else begin
      IRQ_REQ <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // LED open handling
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LED_DISABLE     <= 1'b0;
      LED_DISABLE_IDX <= 8'h00;
    end else begin
      LED_DISABLE <= OPEN_FOUND && cfg_q.open_dis;
      if (OPEN_FOUND) begin
        LED_DISABLE_IDX <= OPEN_IDX;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MEM_LAYOUT      <= LAYOUT_INVALID;
      LAYOUT_VALID    <= 1'b0;
      DOT_CORR_EN     <= 1'b0;
      CFG_LOCKED      <= 1'b0;
      SUPPLY_LOW_FLAG <= 1'b0;
      STATUS          <= 8'h00;
    end else begin
      MEM_LAYOUT      <= cfg_q.layout;
      LAYOUT_VALID    <= (cfg_q.layout >= LAYOUT_FIRST) &&
                         (cfg_q.layout <= LAYOUT_LAST);
      DOT_CORR_EN     <= cfg_q.dot_corr;
      CFG_LOCKED      <= lock_q;
      SUPPLY_LOW_FLAG <= flag_q;
      STATUS          <= status_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Quiet window: no mode, mask or supply-clear change while the event ripples
  sequence s_normal_quiet;
    (!cfg_q.sup_to_pin && !STATUS_CLR[BIT_SUPPLY] && !wr_mask && !wr_cfg) [*3];
  endsequence

  sequence s_target_last;
    EVENTS.frame_shown && EVENTS.last_loop && (EVENTS.frame_num == tframe_q);
  endsequence

  a_autoclr_flag: assert property (
    end_of_show && cfg_q.autoclr && !EVENTS.supply_low |=> !flag_q)
    else $error("supply flag not cleared at end of show");

  a_keep_flag: assert property (
    end_of_show && !cfg_q.autoclr && flag_q |=> flag_q)
    else $error("supply flag lost without auto clear");

  // Flag, status and pin each add a cycle, so the pin is seen after the window
  a_supply_normal: assert property (
    (EVENTS.supply_low && mask_q[BIT_SUPPLY] && !wr_mask && !wr_cfg)
      ##0 s_normal_quiet |=> IRQ_REQ)
    else $error("supply low did not raise pin in normal mode");

  a_pin_direct: assert property (
    cfg_q.sup_to_pin ##1 cfg_q.sup_to_pin |-> IRQ_REQ == $past(flag_q))
    else $error("pin does not follow supply flag");

  a_status_direct: assert property (
    EVENTS.supply_low && cfg_q.sup_to_pin |=> ##1 status_q[BIT_SUPPLY])
    else $error("status not updated in supply pin mode");

  a_open_disable: assert property (
    OPEN_FOUND |=> LED_DISABLE == $past(cfg_q.open_dis))
    else $error("open LED handling disagrees with config");

  a_shared_addr: assert property (
    ADDR_VALID && cfg_q.shared_addr && BUS_ADDR == SHARED_ADDR |=> ADDR_MATCH)
    else $error("shared address not answered");

  a_layout_valid: assert property (
    ##1 LAYOUT_VALID == ($past(cfg_q.layout) != LAYOUT_INVALID &&
                         $past(cfg_q.layout) <= LAYOUT_LAST))
    else $error("layout validity wrong");

  a_lock_hold: assert property (
    lock_q && wr_cfg |=> $stable(cfg_q.layout) && $stable(cfg_q.dot_corr))
    else $error("locked fields changed");

  a_lock_sticky: assert property (
    lock_q |=> lock_q)
    else $error("lock released without reset");

  a_frame_irq: assert property (
    s_target_last ##0 (mask_q[BIT_FRAME] && !cfg_q.sup_to_pin && !wr_mask && !wr_cfg) ##1
      (!wr_mask && !wr_cfg) [*3] |-> IRQ_REQ)
    else $error("frame target did not raise pin");

  a_wdog_irq: assert property (
    EVENTS.wdog_fire && mask_q[BIT_WDOG] && !wr_mask && !wr_cfg
      ##0 s_normal_quiet |-> IRQ_REQ)
    else $error("watchdog did not raise pin");

  a_por_irq: assert property (
    EVENTS.por_active && mask_q[BIT_POR] && !cfg_q.sup_to_pin
      && !wr_mask && !wr_cfg |=> ##1 IRQ_REQ)
    else $error("power-on event did not raise pin");

  a_masked_quiet: assert property (
    !cfg_q.sup_to_pin && ((status_q & mask_q) == 8'h00) |=> !IRQ_REQ)
    else $error("pin raised with nothing unmasked");

  a_thermal_irq: assert property (
    EVENTS.overtemp && mask_q[BIT_THERMAL] && !cfg_q.sup_to_pin
      && !wr_mask && !wr_cfg |=> ##1 IRQ_REQ)
    else $error("overtemperature did not raise pin");

  a_open_irq: assert property (
    EVENTS.open_err && mask_q[BIT_OPEN] && !cfg_q.sup_to_pin
      && !wr_mask && !wr_cfg |=> ##1 IRQ_REQ)
    else $error("open test error did not raise pin");

  a_short_irq: assert property (
    EVENTS.short_err && mask_q[BIT_SHORT] && !cfg_q.sup_to_pin
      && !wr_mask && !wr_cfg |=> ##1 IRQ_REQ)
    else $error("short test error did not raise pin");

  a_movie_irq: assert property (
    EVENTS.movie_end && mask_q[BIT_MOVIE] && !cfg_q.sup_to_pin
      && !wr_mask && !wr_cfg |=> ##1 IRQ_REQ)
    else $error("movie end did not raise pin");

  // A set flag keeps re-setting its status bit, even through a clear
  a_flag_status: assert property (
    flag_q |=> status_q[BIT_SUPPLY])
    else $error("supply flag not recorded in status");

  a_frame_hit: assert property (
    s_target_last |=> frame_hit)
    else $error("last display of target frame missed");

  a_early_loop: assert property (
    EVENTS.frame_shown && !EVENTS.last_loop |=> !frame_hit)
    else $error("frame event fired before the final loop");

  a_other_frame: assert property (
    EVENTS.frame_shown && (EVENTS.frame_num != tframe_q) |=> !frame_hit)
    else $error("frame event fired for another frame");

  // Masking only gates the pin; the event must still reach status
  a_masked_status: assert property (
    EVENTS.wdog_fire |=> status_q[BIT_WDOG])
    else $error("watchdog event not recorded in status");

endmodule

// ===== sim/reg_host.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the register byte port
// ----------------------------------------
module reg_host (
  input  wire logic       clk,   // System clock
  input  wire logic [7:0] rdata, // Read data from the block
  output logic      [7:0] addr,  // Register offset
  output logic      [7:0] wdata, // Write data
  output logic            we,    // Write strobe
  output logic            re     // Read strobe
);
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
  end
  // One write; released lines flip so no stale value lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // One read; data is registered at the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

// ===== sim/led_driver_config_irq_mask_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bench for the config and mask registers
// ----------------------------------------
module led_driver_config_irq_mask_tb_top;
  import led_cfg_pkg::*;
  logic       clk;
  logic       nrst;
  logic [7:0] rdata, addr, wdata, status_clr, status, open_idx, dis_idx;
  logic       we, re, data_wr, addr_valid, addr_match, flag, irq;
  logic       open_found, led_dis, layout_ok, dc_en, locked;
  logic [6:0] bus_addr, dev_addr;
  logic [2:0] layout;
  evt_t       ev;
  int         fail_count, check_count, seed;
  logic [7:0] cfg_m, mask_m, st_m, v;
  logic [5:0] tgt_m;
  logic       flag_m, lock_m;
  logic [7:0] idx_q[$];

  reg_host host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .we(we), .re(re));
  led_cfg_regs dut_u (.CLK(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .DATA_WR(data_wr), .BUS_ADDR(bus_addr),
    .ADDR_VALID(addr_valid), .DEV_ADDR(dev_addr), .ADDR_MATCH(addr_match), .EVENTS(ev),
    .STATUS_CLR(status_clr), .STATUS(status), .SUPPLY_LOW_FLAG(flag), .IRQ_REQ(irq),
    .OPEN_FOUND(open_found), .OPEN_IDX(open_idx), .LED_DISABLE(led_dis),
    .LED_DISABLE_IDX(dis_idx), .MEM_LAYOUT(layout), .LAYOUT_VALID(layout_ok),
    .DOT_CORR_EN(dc_en), .CFG_LOCKED(locked));

  // Free running 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk_out(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value reg %h expected %h seen %h", a, e, g);
    end
  endtask
  // Model keeps reset images; locked fields keep their old value
  task automatic mreset();
    cfg_m = CFG_RESET;
    mask_m = MASK_RESET;
    tgt_m = TFRAME_RESET;
    st_m = 8'h00;
    flag_m = 1'b0;
    lock_m = 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    if (a == CFG_OFFSET) cfg_m = lock_m ? ((d & 8'hE8) | (cfg_m & 8'h17)) : d;
    if (a == MASK_OFFSET) mask_m = d;
    if (a == TFRAME_OFFSET) tgt_m = d[5:0];
  endtask
  task automatic r(input logic [7:0] a);
    logic [7:0] e;
    host_u.rd(a, v);
    e = (a == CFG_OFFSET) ? cfg_m : (a == MASK_OFFSET) ? mask_m :
        (a == TFRAME_OFFSET) ? {2'h0, tgt_m} : 8'h00;
    chk_rd(a, e, v);
  endtask
  function automatic logic exp_irq();
    return cfg_m[6] ? flag_m : |(st_m & mask_m);
  endfunction
  // Pulse one source, then compare status and pin after the pipeline
  task automatic fire(input int b);
    @(posedge clk);
    case (b)
      7: begin
        ev.frame_shown <= 1'b1;
        ev.frame_num <= tgt_m;
        ev.last_loop <= 1'b1;
      end
      6: ev.wdog_fire <= 1'b1;
      5: ev.por_active <= 1'b1;
      4: ev.overtemp <= 1'b1;
      3: ev.supply_low <= 1'b1;
      2: ev.open_err <= 1'b1;
      1: ev.short_err <= 1'b1;
      default: ev.movie_end <= 1'b1;
    endcase
    @(posedge clk);
    ev <= '0;
    st_m[b] = 1'b1;
    if (b == BIT_SUPPLY) flag_m = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_out("status", st_m, status);
    chk_out("irq", exp_irq(), irq);
  endtask
  task automatic clear();
    @(posedge clk);
    status_clr <= 8'hFF;
    @(posedge clk);
    status_clr <= 8'h00;
    st_m = flag_m ? 8'h08 : 8'h00;
    repeat (3) @(posedge clk);
  endtask
  // Picture end; flag clears only with auto clear set
  task automatic pic_end();
    @(posedge clk);
    ev.pic_end <= 1'b1;
    @(posedge clk);
    ev.pic_end <= 1'b0;
    if (cfg_m[7]) flag_m = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_out("flag", flag_m, flag);
    chk_out("irq", exp_irq(), irq);
  endtask
  task automatic amatch(input logic [6:0] a, input logic e);
    @(posedge clk);
    bus_addr <= a;
    addr_valid <= 1'b1;
    @(posedge clk);
    addr_valid <= 1'b0;
    bus_addr <= ~a;
    #1;
    chk_out("match", e, addr_match);
  endtask
  task automatic open_led(input logic e);
    logic [7:0] i;
    i = 8'($random(seed));
    idx_q.push_back(i);
    @(posedge clk);
    open_found <= 1'b1;
    open_idx <= i;
    @(posedge clk);
    open_found <= 1'b0;
    open_idx <= ~i;
    #1;
    chk_out("disable", e, led_dis);
    chk_out("index", idx_q.pop_front(), dis_idx);
  endtask
  task automatic after_reset();
    mreset();
    r(CFG_OFFSET);
    r(MASK_OFFSET);
    r(TFRAME_OFFSET);
    r(8'h0A);
    chk_out("valid", 1'b0, layout_ok);
    chk_out("lock", 1'b0, locked);
  endtask
  task automatic results();
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard well beyond the expected run
  initial begin
    #200000;
    fail_count++;
    results();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    seed = 6;
    data_wr = 1'b0;
    addr_valid = 1'b0;
    bus_addr = 7'h00;
    dev_addr = 7'({$random(seed)} % 63);
    ev = '0;
    status_clr = 8'h00;
    open_found = 1'b0;
    open_idx = 8'h00;
    fail_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    after_reset();
    w(TFRAME_OFFSET, 8'({$random(seed)} % 6));
    // Each source alone unmasked, then masked off
    for (int b = 0; b < 8; b++) begin
      w(MASK_OFFSET, 8'h01 << b);
      fire(b);
      clear();
      w(MASK_OFFSET, 8'h00);
      fire(b);
      clear();
    end
    w(CFG_OFFSET, 8'h00);
    pic_end();
    w(CFG_OFFSET, 8'h80);
    pic_end();
    clear();
    w(CFG_OFFSET, 8'h40);
    fire(BIT_SUPPLY);
    w(CFG_OFFSET, 8'hC0);
    pic_end();
    clear();
    w(CFG_OFFSET, 8'h00);
    // Non-final loop, then a wrong frame: neither may count
    w(MASK_OFFSET, 8'h80);
    @(posedge clk);
    ev.frame_shown <= 1'b1;
    ev.frame_num <= tgt_m;
    @(posedge clk);
    ev.frame_num <= ~tgt_m;
    ev.last_loop <= 1'b1;
    @(posedge clk);
    ev <= '0;
    repeat (4) @(posedge clk);
    #1;
    chk_out("status", st_m, status);
    chk_out("irq", exp_irq(), irq);
    amatch(SHARED_ADDR, 1'b0);
    amatch(dev_addr, 1'b1);
    open_led(1'b0);
    w(CFG_OFFSET, 8'h28);
    amatch(SHARED_ADDR, 1'b1);
    open_led(1'b1);
    // Every layout code with dot correction toggling
    for (int i = 0; i < 8; i++) begin
      w(CFG_OFFSET, 8'(i) | (i[0] ? 8'h10 : 8'h00));
      repeat (2) @(posedge clk);
      #1;
      chk_out("layout", 8'(i), layout);
      chk_out("valid", (i >= 1 && i <= 6), layout_ok);
      chk_out("dotcorr", i[0], dc_en);
    end
    w(CFG_OFFSET, 8'h12);
    @(posedge clk);
    data_wr <= 1'b1;
    @(posedge clk);
    data_wr <= 1'b0;
    lock_m = 1'b1;
    w(CFG_OFFSET, 8'hE5);
    repeat (2) @(posedge clk);
    #1;
    chk_out("lock", 1'b1, locked);
    chk_out("layout", 8'h02, layout);
    r(CFG_OFFSET);
    // Mid-run reset unlocks the configuration
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    after_reset();
    w(CFG_OFFSET, 8'h05);
    r(CFG_OFFSET);
    results();
  end
endmodule
